// File: hw/eps_filter.sv
// Level filter: output follows input only after it has been stable for a count.
// Assumes input synchronous to i_clk; output rises slowly, falls at once when fast_fall.
`timescale 1ns/1ps
module eps_filter
   import eps_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Level in and out
   input wire logic i_fast_fall,
   input wire logic i_level,
   output logic o_level
);
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic lvl_r;
   logic lvl_nxt;

   // Count stable cycles; a drop may bypass the count so loss is seen at once
   always_comb begin
      cnt_nxt = cnt_r;
      lvl_nxt = lvl_r;
      if (i_level == lvl_r) begin
         cnt_nxt = EPS_FILT_RST;
      end else if (!i_level && i_fast_fall) begin
         lvl_nxt = 1'b0;
         cnt_nxt = EPS_FILT_RST;
      end else if (cnt_r >= EPS_FILT_MAX - 4'h1) begin
         lvl_nxt = i_level;
         cnt_nxt = EPS_FILT_RST;
      end else begin
         cnt_nxt = cnt_r + 4'h1;
      end
   end

   // Registers only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= EPS_FILT_RST;
         lvl_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   assign o_level = lvl_r;
endmodule // eps_filter

// File: hw/eps_sequencer.sv
// Power state sequencer driven by supply and enable comparator results.
// Assumes comparator levels synchronous to i_clk and an always-on clock.
// Limitation: a chattering rail comparator holds the processor in reset for as
// long as it chatters, because every drop restarts the rise filter.
`timescale 1ns/1ps
module eps_sequencer
   import eps_pkg::*;
(
   // Clock and asynchronous reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Comparator results
   input wire logic i_input_supply_undervoltage_ok,
   input wire logic i_enable_undervoltage_input_stby_rise,
   input wire logic i_enable_undervoltage_input_stby_fall,
   input wire logic i_enable_undervoltage_input_oper,
   input wire logic i_rail_five_volt_ok,
   input wire logic i_rail_five_volt_fall_ok,
   input wire logic i_rail_three_volt_ok,
   input wire logic i_rail_core_volt_ok,
   // Controls
   output logic o_rails_en,
   output logic o_embedded_processor_run,
   output logic o_embedded_processor_rst_n,
   output logic [1:0] o_state
);
   logic [1:0] sync_r;
   logic [1:0] sync_nxt;
   logic rst_n;
   logic stby_f;
   logic oper_f;
   logic rails_f;
   logic five_f;
   logic sup_f;
   logic in_stby_r;
   logic in_stby_nxt;
   eps_state_t state_r;
   eps_state_t state_nxt;
   logic rails_en_r;
   logic rails_en_nxt;
   logic run_r;
   logic run_nxt;

   // Reset release: ones shift in so the rest leaves reset on a clean edge
   always_comb begin
      sync_nxt = {sync_r[0], 1'b1};
   end

   // Reset release through two flip-flops; entry is asynchronous, release is not
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync_r <= EPS_SYNC_RST;
      end else begin
         sync_r <= sync_nxt;
      end
   end
   assign rst_n = sync_r[1];

   // Filters: rising levels must stay stable, falls act immediately.
   // A slow fall would leave the processor running on a sagging rail, so
   // every loss bypasses the count; only recoveries pay the filter delay.
   eps_filter u_sup (.i_clk(i_clk), .i_rst_n(rst_n), .i_fast_fall(1'b1),
      .i_level(i_input_supply_undervoltage_ok), .o_level(sup_f));
   eps_filter u_oper (.i_clk(i_clk), .i_rst_n(rst_n), .i_fast_fall(1'b1),
      .i_level(i_enable_undervoltage_input_oper), .o_level(oper_f));
   eps_filter u_rails (.i_clk(i_clk), .i_rst_n(rst_n), .i_fast_fall(1'b1),
      .i_level(i_rail_five_volt_ok && i_rail_three_volt_ok && i_rail_core_volt_ok),
      .o_level(rails_f));
   eps_filter u_five (.i_clk(i_clk), .i_rst_n(rst_n), .i_fast_fall(1'b1),
      .i_level(i_rail_five_volt_fall_ok), .o_level(five_f));

   // Standby window with hysteresis: enter above rise level, leave below fall level
   // Not filtered: the two comparator levels already give the dead band
   always_comb begin
      in_stby_nxt = in_stby_r;
      if (!i_enable_undervoltage_input_stby_fall) begin
         in_stby_nxt = 1'b0;
      end else if (i_enable_undervoltage_input_stby_rise) begin
         in_stby_nxt = 1'b1;
      end
   end
   assign stby_f = in_stby_r;

   // Hysteresis register
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_stby_r <= 1'b0;
      end else begin
         in_stby_r <= in_stby_nxt;
      end
   end

   // State follows present inputs every cycle, so nothing stale survives a drop
   always_comb begin
      state_nxt = EPS_SHUTDOWN;
      case (state_r)
         EPS_SHUTDOWN,
         EPS_STANDBY,
         EPS_PENDING,
         EPS_OPERATING: begin
            if (!sup_f || !stby_f) begin
               state_nxt = EPS_SHUTDOWN;
            end else if (!oper_f) begin
               state_nxt = EPS_STANDBY;
            end else if (!rails_f || !five_f) begin
               state_nxt = EPS_PENDING;
            end else begin
               state_nxt = EPS_OPERATING;
            end
         end
         default: state_nxt = EPS_SHUTDOWN;
      endcase
   end

   // State register
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= EPS_SHUTDOWN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Output next values, taken from the next state so that the outputs
   // change on the same edge as the state and never lag it by a cycle
   always_comb begin
      rails_en_nxt = (state_nxt != EPS_SHUTDOWN);
      run_nxt = (state_nxt == EPS_OPERATING);
   end

   // Output flops; processor run drops on the same edge the state leaves operating
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rails_en_r <= 1'b0;
         run_r <= 1'b0;
      end else begin
         rails_en_r <= rails_en_nxt;
         run_r <= run_nxt;
      end
   end

   assign o_rails_en = rails_en_r;
   assign o_embedded_processor_run = run_r;
   assign o_embedded_processor_rst_n = run_r;
   assign o_state = state_r;

   // Assertions: outputs are judged against the filtered levels one edge later, except in the per-state checks (state_r, same cycle) and chk_five_fall,
   // which takes the raw five volt fall level two edges later, and the hysteresis checks, which take the raw standby levels one edge later,
   // so a comparator glitch that the filter swallows never trips them

   // Output levels per state
   chk_run_only_oper: assert property (@(posedge i_clk) disable iff (!rst_n)
      run_r |-> state_r == EPS_OPERATING)
      else $error("processor runs outside operating");
   chk_shut_rails_off: assert property (@(posedge i_clk) disable iff (!rst_n)
      state_r == EPS_SHUTDOWN |-> !rails_en_r)
      else $error("rails on in shutdown");
   chk_stby_rails_on: assert property (@(posedge i_clk) disable iff (!rst_n)
      state_r == EPS_STANDBY |-> rails_en_r && !run_r)
      else $error("standby outputs wrong");

   // Transitions from the filtered levels, and from the raw five volt fall level
   chk_supply_drop: assert property (@(posedge i_clk) disable iff (!rst_n)
      !sup_f |=> state_r == EPS_SHUTDOWN)
      else $error("no shutdown on supply loss");
   chk_oper_drop: assert property (@(posedge i_clk) disable iff (!rst_n)
      sup_f && stby_f && !oper_f |=> state_r == EPS_STANDBY)
      else $error("no standby below operating level");
   chk_rails_pend: assert property (@(posedge i_clk) disable iff (!rst_n)
      sup_f && stby_f && oper_f && !rails_f |=> state_r == EPS_PENDING && !run_r)
      else $error("processor on with rail low");
   chk_five_fall: assert property (@(posedge i_clk) disable iff (!rst_n)
      !i_rail_five_volt_fall_ok |=> ##1 !run_r)
      else $error("no reset on five volt fall");

   // Standby hysteresis
   chk_hyst_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
      in_stby_r && i_enable_undervoltage_input_stby_fall |=> in_stby_r)
      else $error("standby window left above fall level");
   chk_hyst_clear: assert property (@(posedge i_clk) disable iff (!rst_n)
      !i_enable_undervoltage_input_stby_fall |=> !in_stby_r)
      else $error("standby window kept below fall level");
   chk_hyst_band: assert property (@(posedge i_clk) disable iff (!rst_n)
      !in_stby_r && !i_enable_undervoltage_input_stby_rise |=> !in_stby_r)
      else $error("shutdown left below upper standby level");

   // Start-up and loss
   // Every start-up condition met at once
   sequence s_all_ok;
      sup_f && stby_f && oper_f && rails_f && five_f;
   endsequence
   // Processor running while some start-up condition has gone
   sequence s_cond_lost;
      run_r && !(sup_f && stby_f && oper_f && rails_f && five_f);
   endsequence
   chk_loss_reset: assert property (@(posedge i_clk) disable iff (!rst_n)
      s_cond_lost |=> !run_r)
      else $error("reset not reasserted on loss");
   chk_oper_enter: assert property (@(posedge i_clk) disable iff (!rst_n)
      s_all_ok |=> state_r == EPS_OPERATING && run_r)
      else $error("no operating with all conditions met");
   chk_shut_enable: assert property (@(posedge i_clk) disable iff (!rst_n)
      !stby_f |=> state_r == EPS_SHUTDOWN && !rails_en_r && !run_r)
      else $error("no shutdown below standby level");
   chk_stby_rails: assert property (@(posedge i_clk) disable iff (!rst_n)
      sup_f && stby_f |=> rails_en_r)
      else $error("rails off inside standby window");
   chk_rst_rails: assert property (@(posedge i_clk) disable iff (!rst_n)
      !rails_f |=> !o_embedded_processor_rst_n)
      else $error("processor reset released with rail low");
   chk_five_rst: assert property (@(posedge i_clk) disable iff (!rst_n)
      !five_f |=> !run_r)
      else $error("processor runs after five volt fall");
endmodule // eps_sequencer

// File: inc/eps_pkg.sv
// Package for the enable/undervoltage power sequencer: states, filter lengths.
// Assumes comparator inputs already synchronous to i_clk.
package eps_pkg;
   // Sequencer states, Gray coded along shutdown -> standby -> pending -> operating
   typedef enum logic [1:0] {
      EPS_SHUTDOWN = 2'h0,
      EPS_STANDBY = 2'h1,
      EPS_PENDING = 2'h3,
      EPS_OPERATING = 2'h2
   } eps_state_t;
   // Deglitch time on comparator levels, in ns, and its cycle count at 8 ns
   localparam int EPS_CLK_PERIOD_NS = 8;
   localparam int EPS_FILT_TIME_NS = 64;
   localparam int EPS_FILT_CYCLES = (EPS_FILT_TIME_NS + EPS_CLK_PERIOD_NS - 1) / EPS_CLK_PERIOD_NS;
   localparam logic [3:0] EPS_FILT_MAX = 4'(EPS_FILT_CYCLES);
   localparam logic [3:0] EPS_FILT_RST = 4'h0;
   localparam logic [1:0] EPS_SYNC_RST = 2'h0;
endpackage

// File: tb/enable_uvlo_power_sequencer_tb.sv
// Self-checking bench for the power state sequencer.
// Assumes the sequencer's package is compiled first; the bench drives comparator levels.
`timescale 1ns/1ps
module enable_uvlo_power_sequencer_tb;
   import eps_pkg::*;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [7:0] in_v = 8'h00;
   logic o_rails_en;
   logic o_run;
   logic o_rst_n;
   logic [1:0] o_state;
   int n_errors = 0;
   int n_tests = 0;
   int n_cyc = 0;
   // Bundle of outputs: state, rails, run, processor reset
   wire [4:0] obs = {o_state, o_rails_en, o_run, o_rst_n};

   // Inputs: supply, standby rise, standby fall, oper, five, five fall, three, core
   eps_sequencer u_eps_sequencer (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_input_supply_undervoltage_ok(in_v[7]),
      .i_enable_undervoltage_input_stby_rise(in_v[6]),
      .i_enable_undervoltage_input_stby_fall(in_v[5]),
      .i_enable_undervoltage_input_oper(in_v[4]),
      .i_rail_five_volt_ok(in_v[3]),
      .i_rail_five_volt_fall_ok(in_v[2]),
      .i_rail_three_volt_ok(in_v[1]),
      .i_rail_core_volt_ok(in_v[0]),
      .o_rails_en(o_rails_en),
      .o_embedded_processor_run(o_run),
      .o_embedded_processor_rst_n(o_rst_n),
      .o_state(o_state)
   );

   // Free running clock, 8 ns period
   initial begin
      forever #4 i_clk = ~i_clk;
   end

   // Hang guard: all scenarios finish well inside this many cycles
   always @(posedge i_clk) begin
      n_cyc <= n_cyc + 1;
      if (n_cyc == 2000) begin
         n_errors++;
         wrap_up();
      end
   end

   function automatic logic [4:0] ex(eps_state_t s, logic rails, logic run);
      return {s, rails, run, run};
   endfunction

   task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Drive new levels at the falling edge, wait n rising edges, then compare
   task automatic go(input logic [7:0] v, input int n, input string name, input logic [4:0] e);
      @(negedge i_clk);
      in_v = v;
      repeat (n) @(posedge i_clk);
      #1;
      check(name, obs, e);
   endtask

   task automatic t_start();
      go(8'hFF, 16, "all_ok", ex(EPS_OPERATING, 1'b1, 1'b1));
      $display("test start done");
   endtask

   // Falls take one edge to the filter and one to the state
   task automatic t_drops();
      go(8'hEF, 2, "oper_low", ex(EPS_STANDBY, 1'b1, 1'b0));
      go(8'hFF, 16, "oper_back", ex(EPS_OPERATING, 1'b1, 1'b1));
      go(8'hFE, 2, "core_low", ex(EPS_PENDING, 1'b1, 1'b0));
      go(8'hFF, 16, "core_back", ex(EPS_OPERATING, 1'b1, 1'b1));
      go(8'hFB, 2, "five_fall", ex(EPS_PENDING, 1'b1, 1'b0));
      go(8'hFF, 16, "five_back", ex(EPS_OPERATING, 1'b1, 1'b1));
      go(8'h7F, 2, "supply_low", ex(EPS_SHUTDOWN, 1'b0, 1'b0));
      $display("test drops done");
   endtask

   // Only the upper standby level leaves shutdown; the lower one keeps standby.
   // The supply drop left the window set, so enable goes below the lower level first.
   task automatic t_hyst();
      go(8'h80, 16, "en_low", ex(EPS_SHUTDOWN, 1'b0, 1'b0));
      go(8'hA0, 16, "lower_only", ex(EPS_SHUTDOWN, 1'b0, 1'b0));
      go(8'hE0, 2, "upper_set", ex(EPS_STANDBY, 1'b1, 1'b0));
      go(8'hA0, 16, "hold_stby", ex(EPS_STANDBY, 1'b1, 1'b0));
      go(8'h80, 2, "below_low", ex(EPS_SHUTDOWN, 1'b0, 1'b0));
      $display("test hysteresis done");
   endtask

   // A short rising glitch on the operating level must not start the processor
   task automatic t_pulse();
      go(8'hE0, 16, "stby_again", ex(EPS_STANDBY, 1'b1, 1'b0));
      go(8'hFF, 4, "short_up", ex(EPS_STANDBY, 1'b1, 1'b0));
      go(8'hE0, 16, "after_pulse", ex(EPS_STANDBY, 1'b1, 1'b0));
      $display("test pulse done");
   endtask

   // Reset in mid-run drops everything at once; start-up then repeats in full
   task automatic t_reset();
      go(8'hFF, 16, "run_again", ex(EPS_OPERATING, 1'b1, 1'b1));
      @(negedge i_clk);
      i_arst_n = 1'b0;
      #1;
      check("mid_reset", obs, 5'h00);
      repeat (2) @(negedge i_clk);
      i_arst_n = 1'b1;
      go(8'hFF, 16, "after_reset", ex(EPS_OPERATING, 1'b1, 1'b1));
      $display("test reset done");
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (3) @(negedge i_clk);
      check("in_reset", obs, 5'h00);
      i_arst_n = 1'b1;
      t_start();
      t_drops();
      t_hyst();
      t_pulse();
      t_reset();
      wrap_up();
   end
endmodule // enable_uvlo_power_sequencer_tb
